/* fclp_pkg.sv */
// Function
// - port login accept fixed bytes, classes other than 3 zero
// - company code at bytes 22-24, 30-32
// - unique id follows company code, port name
// - same unique id in node name
// - fabric login port nibble 1=A, 2=B
// - fabric login fixed bytes, sizes 08 40
// - process login bytes 8-15 ignored
// - process login accept fixed bytes, rest zero
// - unchecked nibbles and bits are skipped
// - credit unchecked, always operate at zero
// - require fabric port and alternate credit bits
// - size strictly 128..2112, multiple of four
// - frame size from Class 3 field
// - limit is smaller of fabric, initiator sizes
// - store fabric port name
// - changed fabric name: logout, send reject
// - fabric node name neither checked nor stored
// - require class valid and sequential delivery
// - send full duplex opens, accept both kinds
package fclp_pkg;

  // ----------------------------------------
  // payload kinds and lengths
  // ----------------------------------------
  localparam logic [1:0] KIND_PLOGI_ACC = 2'h0;
  localparam logic [1:0] KIND_PRLI_ACC  = 2'h1;
  localparam logic [1:0] KIND_FLOGI     = 2'h2;
  localparam logic [6:0] LEN_LOGIN      = 7'h74;
  localparam logic [6:0] LEN_PRLI       = 7'h14;

  localparam logic [1:0] PORT_NODE = 2'h0;
  localparam logic [1:0] PORT_A    = 2'h1;
  localparam logic [1:0] PORT_B    = 2'h2;

  // ----------------------------------------
  // byte values
  // ----------------------------------------
  localparam logic [7:0] CMD_ACC      = 8'h02;
  localparam logic [7:0] CMD_FLOGI    = 8'h04;
  localparam logic [7:0] CMD_PRLI     = 8'h20;
  localparam logic [7:0] SVC_VER      = 8'h09;
  localparam logic [7:0] ACC_FEAT     = 8'h88;
  localparam logic [7:0] FLOGI_FEAT   = 8'h08;
  localparam logic [7:0] ONE_BYTE     = 8'h01;
  localparam logic [7:0] ALL_ONES     = 8'hff;
  localparam logic [7:0] EDTOV_LO     = 8'hf4;
  localparam logic [7:0] PLOGI_EDTOV  = 8'h01;
  localparam logic [7:0] FLOGI_EDTOV  = 8'h02;
  localparam logic [3:0] NAME_HI      = 4'h2;
  localparam logic [7:0] NODE_ACC     = 8'h20;
  localparam logic [7:0] NODE_FLOGI   = 8'h02;
  localparam logic [7:0] C3_SO        = 8'h80;
  localparam logic [15:0] TX_FS       = 16'h0840;
  localparam logic [7:0] PRLI_B1      = 8'h10;
  localparam logic [7:0] PRLI_B3      = 8'h14;
  localparam logic [7:0] FCP_TYPE     = 8'h08;
  localparam logic [7:0] PRLI_REQ_B6  = 8'h20;
  localparam logic [7:0] PRLI_ACC_B6  = 8'h21;
  localparam logic [7:0] PRLI_REQ_B19 = 8'h22;
  localparam logic [7:0] PRLI_ACC_B19 = 8'h12;

  // ----------------------------------------
  // received field positions and limits
  // ----------------------------------------
  localparam int CF_FPORT_BIT  = 4;
  localparam int CF_ALT_BIT    = 3;
  localparam int SO_VALID_BIT  = 7;
  localparam int SO_SEQ_BIT    = 3;
  localparam logic [6:0] IDX_CF    = 7'd8;
  localparam logic [6:0] IDX_FS_HI = 7'd10;
  localparam logic [6:0] IDX_FS_LO = 7'd11;
  localparam logic [6:0] IDX_PN    = 7'd20;
  localparam logic [6:0] IDX_PN_END = 7'd27;
  localparam logic [6:0] IDX_SO    = 7'd68;
  localparam logic [6:0] IDX_C3_HI = 7'd74;
  localparam logic [6:0] IDX_C3_LO = 7'd75;
  localparam logic [11:0] FS_MIN   = 12'd128;
  localparam logic [11:0] FS_MAX   = 12'd2112;

endpackage

/* fclp_engine.sv */
`timescale 1ns/1ps
module fclp_engine #(
  parameter logic [23:0] COMPANY_CODE = 24'h5a_a5_3c  // arbitrary value
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // unit identity
  input  wire logic [23:0] unit_unique_id,
  // payload transmit
  input  wire logic        tx_start,
  input  wire logic [1:0]  tx_kind,
  input  wire logic [1:0]  tx_port,
  input  wire logic        tx_ready,
  output logic             tx_busy,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  // payload receive
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  input  wire logic        rx_is_flogi_acc,
  output logic             rx_done,
  output logic             rx_ok,
  // login parameters
  input  wire logic [11:0] init_buffer_size,
  output logic             fabric_logged_in,
  output logic [11:0]      rx_buffer_field_size,
  output logic [11:0]      frame_size_limit,
  output logic [63:0]      far_port_name,
  output logic [7:0]       bb_credit,
  // fabric address notification
  input  wire logic        fan_valid,
  input  wire logic [63:0] fan_port_name,
  output logic             implicit_logout,
  output logic             ls_rjt_send,
  // loop open
  input  wire logic        open_in_valid,
  input  wire logic        open_in_full_duplex,
  output logic             open_accept,
  output logic             open_out_full_duplex
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_RUN  = 1'b1
  } fclp_tx_e;

  typedef struct packed {
    fclp_tx_e    st;
    logic [6:0]  idx;
    logic [1:0]  kind;
    logic [1:0]  port;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        tx_last;
    logic [6:0]  rx_idx;
    logic        rx_bad;
    logic        rx_done;
    logic        rx_ok;
    logic [11:0] fs_com;
    logic [11:0] fs_c3;
    logic [63:0] pn_tmp;
    logic [63:0] pn;
    logic        logged;
    logic [11:0] fs_use;
    logic [11:0] limit;
    logic        logout;
    logic        rjt;
    logic        open_ack;
    logic        open_fd;
  } fclp_state_s;

  fclp_state_s s_q;
  fclp_state_s s_d;

  // ----------------------------------------
  // outgoing payload bytes
  // ----------------------------------------
  function automatic logic [7:0] tx_byte(input logic [1:0] kind, input logic [6:0] i,
                                         input logic [1:0] port, input logic [23:0] uid);
    logic flogi;
    flogi   = (kind == fclp_pkg::KIND_FLOGI);
    tx_byte = 8'h00;
    if (kind == fclp_pkg::KIND_PRLI_ACC) begin
      unique case (i)
        7'd0:    tx_byte = fclp_pkg::CMD_ACC;
        7'd1:    tx_byte = fclp_pkg::PRLI_B1;
        7'd3:    tx_byte = fclp_pkg::PRLI_B3;
        7'd4:    tx_byte = fclp_pkg::FCP_TYPE;
        7'd6:    tx_byte = fclp_pkg::PRLI_ACC_B6;
        7'd19:   tx_byte = fclp_pkg::PRLI_ACC_B19;
        default: tx_byte = 8'h00;
      endcase
    end else begin
      unique case (i)
        7'd0:    tx_byte = flogi ? fclp_pkg::CMD_FLOGI : fclp_pkg::CMD_ACC;
        7'd4,
        7'd5:    tx_byte = fclp_pkg::SVC_VER;
        7'd8:    tx_byte = flogi ? fclp_pkg::FLOGI_FEAT : fclp_pkg::ACC_FEAT;
        7'd10,
        7'd74:   tx_byte = fclp_pkg::TX_FS[15:8];
        7'd11,
        7'd75:   tx_byte = fclp_pkg::TX_FS[7:0];
        7'd13,
        7'd77:   tx_byte = flogi ? 8'h00 : fclp_pkg::ALL_ONES;
        7'd15,
        7'd81:   tx_byte = flogi ? 8'h00 : fclp_pkg::ONE_BYTE;
        7'd18:   tx_byte = flogi ? fclp_pkg::FLOGI_EDTOV : fclp_pkg::PLOGI_EDTOV;
        7'd19:   tx_byte = fclp_pkg::EDTOV_LO;
        7'd20:   tx_byte = {fclp_pkg::NAME_HI, 2'b00, port};
        7'd22,
        7'd30:   tx_byte = COMPANY_CODE[23:16];
        7'd23,
        7'd31:   tx_byte = COMPANY_CODE[15:8];
        7'd24,
        7'd32:   tx_byte = COMPANY_CODE[7:0];
        7'd25,
        7'd33:   tx_byte = uid[23:16];
        7'd26,
        7'd34:   tx_byte = uid[15:8];
        7'd27,
        7'd35:   tx_byte = uid[7:0];
        7'd28:   tx_byte = flogi ? fclp_pkg::NODE_FLOGI : fclp_pkg::NODE_ACC;
        7'd68:   tx_byte = fclp_pkg::C3_SO;
        default: tx_byte = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // received byte checks
  // ----------------------------------------
  function automatic logic rx_byte_bad(input logic flogi_acc, input logic [6:0] i, input logic [7:0] b);
    rx_byte_bad = 1'b0;
    if (flogi_acc) begin
      unique case (i)
        7'd0:    rx_byte_bad = (b != fclp_pkg::CMD_ACC);
        7'd4,
        7'd5:    rx_byte_bad = (b != fclp_pkg::SVC_VER);
        7'd8:    rx_byte_bad = !(b[fclp_pkg::CF_FPORT_BIT] && b[fclp_pkg::CF_ALT_BIT]);
        7'd68:   rx_byte_bad = !(b[fclp_pkg::SO_VALID_BIT] && b[fclp_pkg::SO_SEQ_BIT]);
        default: rx_byte_bad = 1'b0;
      endcase
    end else begin
      unique case (i)
        7'd0:    rx_byte_bad = (b != fclp_pkg::CMD_PRLI);
        7'd1:    rx_byte_bad = (b != fclp_pkg::PRLI_B1);
        7'd3:    rx_byte_bad = (b != fclp_pkg::PRLI_B3);
        7'd4:    rx_byte_bad = (b != fclp_pkg::FCP_TYPE);
        7'd6:    rx_byte_bad = (b != fclp_pkg::PRLI_REQ_B6);
        7'd19:   rx_byte_bad = (b != fclp_pkg::PRLI_REQ_B19);
        7'd2, 7'd5, 7'd7,
        7'd16, 7'd17, 7'd18: rx_byte_bad = (b != 8'h00);
        default: rx_byte_bad = 1'b0;
      endcase
    end
  endfunction

  function automatic logic fs_good(input logic [11:0] fs);
    fs_good = (fs > fclp_pkg::FS_MIN) && (fs < fclp_pkg::FS_MAX) && (fs[1:0] == 2'b00);
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic       bad_now;
  logic [6:0] tx_len;
  logic       len_ok;

  always_comb begin
    s_d          = s_q;
    s_d.rx_done  = 1'b0;
    s_d.logout   = 1'b0;
    s_d.rjt      = 1'b0;
    s_d.open_ack = 1'b0;
    s_d.open_fd  = 1'b1;
    tx_len       = (s_q.kind == fclp_pkg::KIND_PRLI_ACC) ? fclp_pkg::LEN_PRLI : fclp_pkg::LEN_LOGIN;
    bad_now      = rx_byte_bad(rx_is_flogi_acc, s_q.rx_idx, rx_data);
    len_ok       = rx_is_flogi_acc ? (s_q.rx_idx == fclp_pkg::LEN_LOGIN - 7'd1)
                                   : (s_q.rx_idx == fclp_pkg::LEN_PRLI - 7'd1);

    // transmit walk
    unique case (s_q.st)
      TX_IDLE: begin
        if (tx_start) begin
          s_d.st       = TX_RUN;
          s_d.kind     = tx_kind;
          s_d.port     = (tx_kind == fclp_pkg::KIND_FLOGI && tx_port == fclp_pkg::PORT_NODE) ?
                         fclp_pkg::PORT_A : tx_port;
          s_d.idx      = 7'd0;
          s_d.tx_valid = 1'b1;
          s_d.tx_last  = 1'b0;
          s_d.tx_data  = tx_byte(tx_kind, 7'd0, tx_port, unit_unique_id);
        end
      end
      TX_RUN: begin
        if (tx_ready) begin
          if (s_q.tx_last) begin
            s_d.st       = TX_IDLE;
            s_d.tx_valid = 1'b0;
            s_d.tx_last  = 1'b0;
            s_d.tx_data  = 8'h00;
          end else begin
            s_d.idx     = s_q.idx + 7'd1;
            s_d.tx_data = tx_byte(s_q.kind, s_q.idx + 7'd1, s_q.port, unit_unique_id);
            s_d.tx_last = (s_q.idx + 7'd2 == tx_len);
          end
        end
      end
    endcase

    // receive check and capture
    if (rx_valid) begin
      s_d.rx_idx = (s_q.rx_idx == 7'h7f) ? s_q.rx_idx : s_q.rx_idx + 7'd1;
      s_d.rx_bad = s_q.rx_bad | bad_now;
      if (rx_is_flogi_acc) begin
        if (s_q.rx_idx == fclp_pkg::IDX_FS_HI) s_d.fs_com[11:8] = rx_data[3:0];
        if (s_q.rx_idx == fclp_pkg::IDX_FS_LO) s_d.fs_com[7:0]  = rx_data;
        if (s_q.rx_idx == fclp_pkg::IDX_C3_HI) s_d.fs_c3[11:8]  = rx_data[3:0];
        if (s_q.rx_idx == fclp_pkg::IDX_C3_LO) s_d.fs_c3[7:0]   = rx_data;
        if (s_q.rx_idx >= fclp_pkg::IDX_PN && s_q.rx_idx <= fclp_pkg::IDX_PN_END) begin
          s_d.pn_tmp = {s_q.pn_tmp[55:0], rx_data};
        end
      end
      if (rx_last) begin
        s_d.rx_done = 1'b1;
        s_d.rx_idx  = 7'd0;
        s_d.rx_bad  = 1'b0;
        s_d.rx_ok   = !s_q.rx_bad && !bad_now && len_ok &&
                      (!rx_is_flogi_acc || (fs_good(s_q.fs_com) && fs_good(s_d.fs_c3)));
        if (rx_is_flogi_acc && s_d.rx_ok) begin
          s_d.pn     = s_q.pn_tmp;
          s_d.logged = 1'b1;
          s_d.fs_use = s_d.fs_c3;
        end
      end
    end

    // transmit limit follows the tighter of the two logins
    s_d.limit = (init_buffer_size < s_q.fs_use) ? init_buffer_size : s_q.fs_use;

    // fabric name change
    if (fan_valid && s_q.logged && fan_port_name != s_q.pn) begin
      s_d.logout = 1'b1;
      s_d.rjt    = 1'b1;
      s_d.logged = 1'b0;
    end

    if (open_in_valid) begin
      s_d.open_ack = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign tx_busy              = (s_q.st == TX_RUN);
  assign tx_valid             = s_q.tx_valid;
  assign tx_data              = s_q.tx_data;
  assign tx_last              = s_q.tx_last;
  assign rx_done              = s_q.rx_done;
  assign rx_ok                = s_q.rx_ok;
  assign fabric_logged_in     = s_q.logged;
  assign rx_buffer_field_size = s_q.fs_use;
  assign frame_size_limit     = s_q.limit;
  assign far_port_name        = s_q.pn;
  assign bb_credit            = 8'h00;
  assign implicit_logout      = s_q.logout;
  assign ls_rjt_send          = s_q.rjt;
  assign open_accept          = s_q.open_ack;
  assign open_out_full_duplex = s_q.open_fd;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic open_hd_seen;
  assign open_hd_seen = open_in_valid && !open_in_full_duplex;

  full_duplex_a: assert property ($past(rst) == 1'b0 |-> open_out_full_duplex)
    else $error("outgoing open not full duplex");
  open_accept_a: assert property (open_in_valid |=> open_accept)
    else $error("incoming open not accepted");
  plogi_cmd_a: assert property (s_q.st == TX_IDLE && tx_start && tx_kind == fclp_pkg::KIND_PLOGI_ACC
                                |=> tx_valid && tx_data == 8'h02)
    else $error("login accept command byte wrong");
  flogi_cmd_a: assert property (s_q.st == TX_IDLE && tx_start && tx_kind == fclp_pkg::KIND_FLOGI
                                |=> tx_data == 8'h04 && !tx_last)
    else $error("fabric login command byte wrong");
  port_nibble_a: assert property (tx_valid && s_q.kind != fclp_pkg::KIND_PRLI_ACC && s_q.idx == 7'd20
                                  |-> tx_data[3:0] == {2'b00, s_q.port})
    else $error("port identifier nibble wrong");
  unique_id_a: assert property (tx_valid && s_q.kind != fclp_pkg::KIND_PRLI_ACC && s_q.idx == 7'd33
                                |-> tx_data == unit_unique_id[23:16])
    else $error("node name unique id wrong");
  company_code_a: assert property (tx_valid && s_q.kind != fclp_pkg::KIND_PRLI_ACC && s_q.idx == 7'd22
                                   |-> tx_data == COMPANY_CODE[23:16])
    else $error("company code byte wrong");
  prli_len_a: assert property (tx_valid && tx_last && s_q.kind == fclp_pkg::KIND_PRLI_ACC
                               |-> s_q.idx == 7'd19 && tx_data == 8'h12)
    else $error("process login accept tail wrong");
  fan_logout_a: assert property (fan_valid && fabric_logged_in && fan_port_name != far_port_name
                                 |=> implicit_logout && ls_rjt_send && !fabric_logged_in)
    else $error("name change did not log out");
  limit_min_a: assert property (##1 frame_size_limit <= $past(init_buffer_size))
    else $error("frame limit above initiator size");
  credit_zero_a: assert property (bb_credit == 8'h00)
    else $error("nonzero buffer credit");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("payload byte changed while stalled");
  class3_opt_a: assert property (tx_valid && s_q.kind != fclp_pkg::KIND_PRLI_ACC && s_q.idx == 7'd68
                                 |-> tx_data == fclp_pkg::C3_SO)
    else $error("class 3 service option byte wrong");
  fs_range_a: assert property (fabric_logged_in |-> rx_buffer_field_size > fclp_pkg::FS_MIN &&
                               rx_buffer_field_size < fclp_pkg::FS_MAX && rx_buffer_field_size[1:0] == 2'b00)
    else $error("stored buffer size out of range");
  limit_fabric_a: assert property (##1 frame_size_limit <= $past(rx_buffer_field_size))
    else $error("frame limit above fabric size");
  fan_keep_a: assert property (fan_valid && fabric_logged_in && fan_port_name == far_port_name
                               |=> !implicit_logout && !ls_rjt_send)
    else $error("unchanged name caused logout");

  login_sent_c: cover property (tx_valid && tx_last && tx_ready && s_q.kind == fclp_pkg::KIND_PLOGI_ACC);
  fabric_ok_c: cover property (rx_done && rx_ok && fabric_logged_in);
  logout_c: cover property (implicit_logout);
  half_open_c: cover property (open_hd_seen ##1 open_accept);
  reject_seen_c: cover property (rx_done && !rx_ok);

endmodule

/* fclp_far_model.sv */
`timescale 1ns/1ps
module fclp_far_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // scenario control
  input  wire logic        send,
  input  wire logic        fab,
  input  wire logic        slow,
  input  wire logic [11:0] fs_com,
  input  wire logic [11:0] fs_c3,
  input  wire logic [7:0]  cf,
  input  wire logic [7:0]  so,
  input  wire logic [63:0] pname,
  // engine receive side
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  output logic             rx_last,
  output logic             rx_is_flogi_acc,
  // engine transmit side
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_last,
  output logic             tx_ready
);
  logic [7:0] pl  [0:115];
  logic [7:0] cap [0:115];
  int         idx;
  int         len;
  int         cn;
  int         got_n;
  int         seen;
  logic       active;
  logic       gap;
  localparam logic [63:0] PRLI_HEAD = 64'h20_10_00_14_08_00_20_00;

  // ----------------------------------------
  // payload source, idle data inverts every cycle
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= 8'h00;
      rx_is_flogi_acc <= 1'b0;
      active <= 1'b0;
      gap <= 1'b0;
      idx <= 0;
    end else if (send && !active) begin
      for (int i = 0; i < 116; i++) pl[i] <= 8'ha5 ^ i[7:0];
      if (fab) begin
        pl[0] <= 8'h02;
        pl[4] <= 8'h09;
        pl[5] <= 8'h09;
        pl[8] <= cf;
        pl[10] <= {4'h0, fs_com[11:8]};
        pl[11] <= fs_com[7:0];
        for (int i = 0; i < 8; i++) pl[20 + i] <= pname[63 - 8 * i -: 8];
        pl[68] <= so;
        pl[74] <= {4'h0, fs_c3[11:8]};
        pl[75] <= fs_c3[7:0];
        len <= 116;
      end else begin
        for (int i = 0; i < 8; i++) pl[i] <= PRLI_HEAD[63 - 8 * i -: 8];
        for (int i = 16; i < 19; i++) pl[i] <= 8'h00;
        pl[19] <= so;
        len <= 20;
      end
      rx_is_flogi_acc <= fab;
      active <= 1'b1;
      idx <= 0;
      gap <= 1'b0;
    end else if (active && slow && gap) begin
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~rx_data;
      gap <= 1'b0;
    end else if (active) begin
      rx_valid <= 1'b1;
      rx_data <= pl[idx];
      rx_last <= (idx == len - 1);
      idx <= idx + 1;
      gap <= 1'b1;
      active <= (idx != len - 1);
    end else begin
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~rx_data;
    end
  end

  // ----------------------------------------
  // payload sink, stalls every other cycle when slow
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_ready <= 1'b0;
      cn <= 0;
      got_n <= 0;
      seen <= 0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        if (cn < 116) cap[cn] <= tx_data;
        cn <= tx_last ? 0 : cn + 1;
        if (tx_last) begin
          got_n <= cn + 1;
          seen <= seen + 1;
        end
      end
    end
  end
endmodule

/* fc_login_payload_engine_bench.sv */
`timescale 1ns/1ps
module fc_login_payload_engine_bench;
  localparam logic [23:0] CC = 24'h3c_96_e1; // arbitrary value
  typedef struct packed {
    logic fab; logic [11:0] fc; logic [11:0] f3; logic [7:0] cf; logic [7:0] so; logic ok;
  } fclp_row_s;
  logic clk, rst, tx_start, tx_busy, tx_valid, tx_last, tx_ready, rx_valid, rx_last, rx_fab, rx_done, rx_ok;
  logic fabric_logged_in, fan_valid, implicit_logout, ls_rjt_send, open_in_valid, open_in_full_duplex;
  logic open_accept, open_out_full_duplex, m_send, m_fab, m_slow;
  logic [1:0] tx_kind, tx_port;
  logic [7:0] tx_data, rx_data, bb_credit, m_cf, m_so;
  logic [11:0] init_buffer_size, rx_buffer_field_size, frame_size_limit, m_fc, m_f3;
  logic [23:0] uid;
  logic [63:0] far_port_name, fan_port_name, m_pn, pn_last;
  int n_fail, tests_run, cycles, s0, n;
  fclp_row_s rows [0:12];

  fclp_engine #(.COMPANY_CODE(CC)) i_fclp_engine (.clk(clk), .rst(rst), .unit_unique_id(uid),
    .tx_start(tx_start), .tx_kind(tx_kind), .tx_port(tx_port), .tx_ready(tx_ready), .tx_busy(tx_busy),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_is_flogi_acc(rx_fab), .rx_done(rx_done), .rx_ok(rx_ok),
    .init_buffer_size(init_buffer_size), .fabric_logged_in(fabric_logged_in),
    .rx_buffer_field_size(rx_buffer_field_size), .frame_size_limit(frame_size_limit),
    .far_port_name(far_port_name), .bb_credit(bb_credit), .fan_valid(fan_valid),
    .fan_port_name(fan_port_name), .implicit_logout(implicit_logout), .ls_rjt_send(ls_rjt_send),
    .open_in_valid(open_in_valid), .open_in_full_duplex(open_in_full_duplex), .open_accept(open_accept),
    .open_out_full_duplex(open_out_full_duplex));
  fclp_far_model i_fclp_far_model (.clk(clk), .rst(rst), .send(m_send), .fab(m_fab), .slow(m_slow),
    .fs_com(m_fc), .fs_c3(m_f3), .cf(m_cf), .so(m_so), .pname(m_pn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_is_flogi_acc(rx_fab), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

  always #12.5 clk = ~clk;

  // ----------------------------------------
  // comparison, verdict and hang guard
  // ----------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic wait_for(input bit rx_side);
    for (int w = 0; w < 600; w++) begin
      @(posedge clk);
      #1;
      if (rx_side ? (rx_done === 1'b1) : (i_fclp_far_model.seen != s0)) return;
    end
    check(64'h0, 64'h1);
  endtask

  function automatic logic [7:0] exp_b(input logic [1:0] k, input logic [1:0] p, input int i);
    logic f;
    f = (k == 2'h2);
    if (k == 2'h1) begin
      case (i)
        0: return 8'h02;
        1: return 8'h10;
        3: return 8'h14;
        4: return 8'h08;
        6: return 8'h21;
        19: return 8'h12;
        default: return 8'h00;
      endcase
    end
    case (i)
      0: return f ? 8'h04 : 8'h02;
      4, 5: return 8'h09;
      8: return f ? 8'h08 : 8'h88;
      10, 74: return 8'h08;
      11, 75: return 8'h40;
      13, 77: return f ? 8'h00 : 8'hff;
      15, 81: return f ? 8'h00 : 8'h01;
      18: return f ? 8'h02 : 8'h01;
      19: return 8'hf4;
      20: return {6'h08, (f && p == 2'h0) ? 2'h1 : p};
      22, 30: return CC[23:16];
      23, 31: return CC[15:8];
      24, 32: return CC[7:0];
      25, 33: return uid[23:16];
      26, 34: return uid[15:8];
      27, 35: return uid[7:0];
      28: return f ? 8'h02 : 8'h20;
      68: return 8'h80;
      default: return 8'h00;
    endcase
  endfunction

  initial begin
    {clk, tx_start, tx_kind, tx_port, fan_valid, fan_port_name, open_in_valid, open_in_full_duplex} = '0;
    {m_send, m_fab, m_slow, m_fc, m_f3, m_cf, m_so, m_pn, pn_last, n_fail, tests_run, cycles} = '0;
    rst = 1'b1;
    uid = 24'h71_c5_3a;
    init_buffer_size = 12'd1536;
    rows = '{'{1'b0, 12'h800, 12'h400, 8'h18, 8'h22, 1'b1}, '{1'b0, 12'h800, 12'h400, 8'h18, 8'h23, 1'b0},
             '{1'b1, 12'h800, 12'h400, 8'h18, 8'h88, 1'b1}, '{1'b1, 12'h800, 12'h080, 8'h18, 8'h88, 1'b0},
             '{1'b1, 12'h800, 12'h840, 8'h18, 8'h88, 1'b0}, '{1'b1, 12'h084, 12'h83c, 8'h18, 8'h88, 1'b1},
             '{1'b1, 12'h800, 12'h402, 8'h18, 8'h88, 1'b0}, '{1'b1, 12'h080, 12'h400, 8'h18, 8'h88, 1'b0},
             '{1'b1, 12'h800, 12'h400, 8'h08, 8'h88, 1'b0}, '{1'b1, 12'h800, 12'h400, 8'h10, 8'h88, 1'b0},
             '{1'b1, 12'h800, 12'h400, 8'h18, 8'h80, 1'b0}, '{1'b1, 12'h800, 12'h400, 8'h18, 8'h08, 1'b0},
             '{1'b1, 12'h800, 12'h400, 8'hff, 8'hff, 1'b1}};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(tx_valid, 1'b0);
    check(rx_done, 1'b0);
    check(bb_credit, 8'h00);
    check(open_out_full_duplex, 1'b1);
    // ----------------------------------------
    // received payloads
    // ----------------------------------------
    for (int r = 0; r < 13; r++) begin
      @(posedge clk);
      {m_fab, m_fc, m_f3, m_cf, m_so} <= rows[r][41:1];
      m_slow <= r[0];
      m_pn <= {56'h20_00_a1_b2_c3_d4_e5, r[7:0]};
      m_send <= 1'b1;
      @(posedge clk);
      m_send <= 1'b0;
      wait_for(1'b1);
      check(rx_ok, rows[r].ok);
      if (rows[r].fab && rows[r].ok) begin
        pn_last = m_pn;
        check(fabric_logged_in, 1'b1);
        check(rx_buffer_field_size, rows[r].f3);
      end
      if (rows[r].fab) check(far_port_name, pn_last);
      @(posedge clk);
      #1;
      if (rows[r].fab && rows[r].ok) check(frame_size_limit, rows[r].f3 < 12'd1536 ? rows[r].f3 : 12'd1536);
    end
    // ----------------------------------------
    // name change notification
    // ----------------------------------------
    for (int c = 0; c < 2; c++) begin
      @(posedge clk);
      fan_port_name <= c ? ~pn_last : pn_last;
      fan_valid <= 1'b1;
      @(posedge clk);
      fan_valid <= 1'b0;
      #1;
      check(implicit_logout, c[0]);
      check(ls_rjt_send, c[0]);
    end
    @(posedge clk);
    #1;
    check(fabric_logged_in, 1'b0);
    // ----------------------------------------
    // transmitted payloads, one start refused
    // ----------------------------------------
    for (int j = 0; j < 7; j++) begin
      @(posedge clk);
      s0 = i_fclp_far_model.seen;
      m_slow <= j[0];
      tx_kind <= (j < 3) ? 2'h0 : (j == 3) ? 2'h1 : 2'h2;
      tx_port <= (j < 3) ? j[1:0] : (j == 4) ? 2'h2 : (j == 6) ? 2'h0 : 2'h1;
      tx_start <= 1'b1;
      @(posedge clk);
      tx_start <= 1'b0;
      #1;
      check(tx_busy, 1'b1);
      if (j == 3) begin
        repeat (3) @(posedge clk);
        tx_kind <= 2'h2;
        tx_start <= 1'b1;
        @(posedge clk);
        tx_start <= 1'b0;
        tx_kind <= 2'h1;
      end
      wait_for(1'b0);
      check(tx_busy, 1'b0);
      n = (tx_kind == 2'h1) ? 20 : 116;
      check(i_fclp_far_model.got_n, n);
      for (int i = 0; i < n; i++) check(i_fclp_far_model.cap[i], exp_b(tx_kind, tx_port, i));
      repeat (8) @(posedge clk);
      check(i_fclp_far_model.seen, s0 + 1);
    end
    // ----------------------------------------
    // loop opens of both kinds
    // ----------------------------------------
    for (int o = 0; o < 2; o++) begin
      @(posedge clk);
      open_in_valid <= 1'b1;
      open_in_full_duplex <= o[0];
      @(posedge clk);
      open_in_valid <= 1'b0;
      #1;
      check(open_accept, 1'b1);
    end
    @(posedge clk);
    #1;
    check(open_accept, 1'b0);
    tally_and_finish();
  end
endmodule
